// [far_side_model.sv]
`timescale 1ns/10ps
`default_nettype none

module far_side_model
  import window_router_pkg::*;
(
  input  wire logic     clk,
  input  wire sub_bus_s uart_bus,
  input  wire sub_bus_s can_bus,
  input  wire logic     cs_n,
  input  wire logic     sck,
  input  wire logic     mosi,
  output logic [15:0]   uart_rdata,
  output logic [15:0]   can_rdata,
  output logic          miso
);
  localparam logic [15:0] RESULT = 16'h3c96;
  logic [15:0] shift_reg;
  logic [15:0] cmd_reg;
  logic [4:0]  rise_reg;
  logic        sck_reg;
  logic        cs_reg;
  logic        tog_reg = 1'b0;

  // cores answer combinationally from the address
  assign uart_rdata = {8'ha5, uart_bus.addr};
  assign can_rdata  = {8'hc3, can_bus.addr};
  // idle data line toggles so no stale level is seen
  assign miso = cs_n ? tog_reg : RESULT[4'hf - rise_reg[3:0]];

  // converter shifts on each serial clock rise
  always_ff @(posedge clk) begin
    sck_reg <= sck;
    cs_reg  <= cs_n;
    tog_reg <= ~tog_reg;
    if (cs_n) begin
      rise_reg <= 5'h00;
    end else if (sck && !sck_reg) begin
      rise_reg  <= rise_reg + 5'h01;
      shift_reg <= {shift_reg[14:0], mosi};
    end
    if (cs_n && !cs_reg) begin
      cmd_reg <= {9'h000, shift_reg[15:9]};
    end
  end
endmodule

`default_nettype wire

// [subdevice_window_gpio_adc_asserts.sv]
`timescale 1ns/10ps
`default_nettype none

module window_checker
  import window_router_pkg::*;
#(
  parameter int FRAME_CYC = ADC_FRAME_CYC
) (
  input wire logic        SYS_CLK,
  input wire logic        ARST_N,
  input wire logic [4:0]  BUS_ADDR,
  input wire logic        BUS_WR,
  input wire logic        BUS_RD,
  input wire logic [15:0] BUS_WDATA,
  input wire logic [15:0] BUS_RDATA,
  input wire logic        BUS_RVALID,
  input wire sub_bus_s    UART_BUS,
  input wire sub_bus_s    CAN_BUS,
  input wire logic [15:0] GPIO_OUT,
  input wire logic [7:0]  GPIO_IN,
  input wire logic        ADC_CS_N
);
  logic [7:0]  sel_reg;
  logic [11:0] gap_reg;
  logic [7:0]  sub_addr;
  logic        sel_hit;

  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!ARST_N);

  // shadow of the select register and the window target
  assign sel_hit  = BUS_ADDR[4:1] == 4'hf;
  assign sub_addr = {sel_reg[3:0], 4'h0} + {3'h0, BUS_ADDR[4:1], 1'b0};
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) sel_reg <= 8'h00;
    else if (BUS_WR && sel_hit) sel_reg <= BUS_WDATA[7:0];
  end
  // cycles since the last frame start
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) gap_reg <= 12'h000;
    else if ($fell(ADC_CS_N)) gap_reg <= 12'h000;
    else if (gap_reg != 12'hfff) gap_reg <= gap_reg + 12'h001;
  end

  chk_read_answer: assert property (BUS_RD |-> ##2 BUS_RVALID)
    else $error("read not answered");
  chk_answer_cause: assert property (BUS_RVALID |-> $past(BUS_RD, 2))
    else $error("answer without read");
  chk_select_read: assert property (BUS_RD && sel_hit |->
    ##2 BUS_RDATA == {8'h00, $past(sel_reg, 2)})
    else $error("select readback wrong");
  chk_uart_fwd: assert property (BUS_RD && sel_reg[7:4] == 4'h0 && !sel_hit |=>
    UART_BUS.rd && UART_BUS.addr == $past(sub_addr))
    else $error("uart read not forwarded");
  chk_can_fwd: assert property (BUS_WR && sel_reg[7:4] == 4'h1 && !sel_hit |=>
    CAN_BUS.wr && CAN_BUS.addr == $past(sub_addr) && CAN_BUS.wdata == $past(BUS_WDATA))
    else $error("can write not forwarded");
  chk_gpio_write: assert property (BUS_WR && sel_reg == 8'h30 && BUS_ADDR[4:1] == 4'h0 |=>
    GPIO_OUT == $past(BUS_WDATA))
    else $error("gpio outputs not written");
  chk_gpio_hold: assert property ($changed(GPIO_OUT) |->
    $past(BUS_WR) && $past(sel_reg) == 8'h30)
    else $error("gpio outputs changed alone");
  chk_gpio_input: assert property (BUS_RD && sel_reg == 8'h30 && BUS_ADDR[4:1] == 4'h1 |->
    ##2 BUS_RDATA == {8'h00, $past(GPIO_IN, 2)})
    else $error("gpio input read wrong");
  chk_frame_hold: assert property ($fell(ADC_CS_N) |-> !ADC_CS_N [*8])
    else $error("frame select dropped early");
  chk_frame_gap: assert property (gap_reg <= FRAME_CYC)
    else $error("conversions not continuous");

  cov_can_page: cover property (BUS_RD && sel_reg == 8'h12);
  cov_adc_read: cover property (BUS_RD && sel_reg == 8'h20);
  cov_gpio_in: cover property (BUS_RD && sel_reg == 8'h30 && BUS_ADDR == 5'h02);
endmodule

bind subdevice_window_router window_checker #(.FRAME_CYC(FRAME_CYC)) chk_i (
  .SYS_CLK(SYS_CLK), .ARST_N(ARST_N), .BUS_ADDR(BUS_ADDR), .BUS_WR(BUS_WR),
  .BUS_RD(BUS_RD), .BUS_WDATA(BUS_WDATA), .BUS_RDATA(BUS_RDATA),
  .BUS_RVALID(BUS_RVALID), .UART_BUS(UART_BUS), .CAN_BUS(CAN_BUS),
  .GPIO_OUT(GPIO_OUT), .GPIO_IN(GPIO_IN), .ADC_CS_N(ADC_CS_N));

`default_nettype wire

// [subdevice_window_gpio_adc_bench.sv]
`timescale 1ns/10ps
`default_nettype none

module subdevice_window_gpio_adc_bench;
  import window_router_pkg::*;
  localparam int FC = 40;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [4:0]  addr = 5'h00;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [15:0] wdata = 16'h0000;
  logic [7:0]  gpio_in = 8'h5a;
  logic [15:0] rdata, gpio_out, uart_rd, can_rd;
  logic        rvalid, cs_n, sck, mosi, miso;
  sub_bus_s    uart_bus, can_bus;
  int          errors = 0;
  int          checks = 0;

  always #2 clk = ~clk;

  subdevice_window_router #(.FRAME_CYC(FC), .SCK_HALF(1)) dut (
    .SYS_CLK(clk), .ARST_N(rst_n), .BUS_ADDR(addr), .BUS_WR(wr), .BUS_RD(rd),
    .BUS_WDATA(wdata), .BUS_RDATA(rdata), .BUS_RVALID(rvalid),
    .UART_BUS(uart_bus), .UART_RDATA(uart_rd), .CAN_BUS(can_bus),
    .CAN_RDATA(can_rd), .GPIO_OUT(gpio_out), .GPIO_IN(gpio_in),
    .ADC_CS_N(cs_n), .ADC_SCK(sck), .ADC_MOSI(mosi), .ADC_MISO(miso));

  far_side_model m (
    .clk(clk), .uart_bus(uart_bus), .can_bus(can_bus), .cs_n(cs_n), .sck(sck),
    .mosi(mosi), .uart_rdata(uart_rd), .can_rdata(can_rd), .miso(miso));

  // ----------------------------------------------------------------
  // host cycles and comparison
  // ----------------------------------------------------------------
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bw(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask
  task automatic br(input logic [4:0] a, input logic [15:0] e);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    // answer stands for one cycle only, two edges after the request edge
    @(posedge clk);
    #1;
    cmp({15'h0000, rvalid}, 16'h0001);
    cmp(rdata, e);
  endtask
  task automatic complete_run;
    $display("errors=%0d checks=%0d", errors, checks);
    if (errors == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_uart;
    br(5'h1e, 16'h0000);
    bw(5'h1e, 16'h0000);
    br(5'h04, 16'ha504);
  endtask
  task automatic t_can;
    bw(5'h1e, 16'h0012);
    br(5'h1e, 16'h0012);
    br(5'h06, 16'hc326);
    br(5'h1c, 16'hc33c);
    bw(5'h0a, 16'h1357);
    cmp(can_bus.wdata, 16'h1357);
    cmp({7'h00, can_bus.wr, can_bus.addr}, 16'h012a);
  endtask
  task automatic t_gpio;
    cmp(gpio_out, 16'h0000);
    bw(5'h1e, 16'h0030);
    bw(5'h00, 16'hbeef);
    cmp(gpio_out, 16'hbeef);
    br(5'h02, 16'h005a);
    bw(5'h02, 16'hffff);
    br(5'h02, 16'h005a);
    @(posedge clk);
    gpio_in <= 8'ha5;
    br(5'h02, 16'h00a5);
    br(5'h00, 16'hbeef);
    bw(5'h1e, 16'hff40);
    br(5'h1e, 16'h0040);
    br(5'h00, 16'h0000);
  endtask
  task automatic t_adc;
    int n;
    logic q;
    n = 0;
    q = 1'b1;
    bw(5'h1e, 16'h0020);
    bw(5'h00, 16'h0055);
    bw(5'h04, 16'h007f);
    repeat (3 * FC) @(posedge clk);
    cmp(m.cmd_reg, 16'h0055);
    br(5'h00, 16'h3c96);
    br(5'h04, 16'h0000);
    cmp(gpio_out, 16'hbeef);
    // start from the settled select level so a frame in flight is no edge
    q = cs_n;
    repeat (4 * FC) begin
      @(posedge clk);
      #1;
      if (q && !cs_n) n++;
      q = cs_n;
    end
    cmp(16'(n), 16'h0004);
  endtask

  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    t_uart();
    t_can();
    t_gpio();
    t_adc();
    complete_run();
  end

  // cut a hang short
  initial begin
    #20000;
    errors++;
    complete_run();
  end
endmodule

`default_nettype wire

// [subdevice_window_router.sv]
// How it works
// R1 - select 0x1 shows CAN space at base
// R2 - low nibble pages CAN register space
// R3 - writing 0x00 selects UART at offset zero
// R4 - writing 0x30 selects GPIO at offset zero
// R5 - GPIO word zero drives sixteen outputs
// R6 - GPIO word two low byte reads inputs
// R7 - writing 0x20 selects ADC at offset zero
// R8 - ADC has one register at offset zero
// R9 - ADC write sends 7-bit command serially
// R10 - ADC converts continuously at 190k conversions per second
// R11 - ADC read returns latest conversion result
// R12 - select register at 0x1e, bits 7-4 device
// R13 - bits 3-0 shift window by 16 bytes
// R14 - offsets 0x00-0x1d form sub-device window
// R15 - host uses 16-bit cycles only
// R16 - GPIO input upper byte zero, writes ignored
`timescale 1ns/10ps
`default_nettype none

module subdevice_window_router
  import window_router_pkg::*;
#(
  parameter int FRAME_CYC = ADC_FRAME_CYC,
  parameter int SCK_HALF  = ADC_SCK_HALF
) (
  input  wire logic                   SYS_CLK,
  input  wire logic                   ARST_N,
  input  wire logic [HOST_ADDR_W-1:0] BUS_ADDR,
  input  wire logic                   BUS_WR,
  input  wire logic                   BUS_RD,
  input  wire logic [DATA_W-1:0]      BUS_WDATA,
  output logic      [DATA_W-1:0]      BUS_RDATA,
  output logic                        BUS_RVALID,
  output sub_bus_s                    UART_BUS,
  input  wire logic [DATA_W-1:0]      UART_RDATA,
  output sub_bus_s                    CAN_BUS,
  input  wire logic [DATA_W-1:0]      CAN_RDATA,
  output logic      [15:0]            GPIO_OUT,
  input  wire logic [7:0]             GPIO_IN,
  output logic                        ADC_CS_N,
  output logic                        ADC_SCK,
  output logic                        ADC_MOSI,
  input  wire logic                   ADC_MISO
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (SCK_HALF < 1 || FRAME_CYC < 2 * SCK_HALF * ADC_FRAME_BITS + 4) begin : bad_timing
    $error("converter frame does not fit in the conversion period");
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // effective sub-device byte address from window offset and page
  function automatic logic [SUB_ADDR_W-1:0] eff_addr(input logic [4:0] ofs,
                                                      input logic [3:0] page);
    eff_addr = SUB_ADDR_W'({page, 4'h0}) + SUB_ADDR_W'(ofs);
  endfunction

  // ----------------------------------------------------------------
  // request decode
  // ----------------------------------------------------------------
  logic [7:0]            win_select_reg;
  logic [3:0]            dev_sel;
  logic [3:0]            page_sel;
  logic [4:0]            word_ofs;
  logic                  hit_select;
  logic                  hit_window;
  logic [SUB_ADDR_W-1:0] sub_addr;

  // byte lane 0 is forced, every access is a full word
  assign word_ofs   = {BUS_ADDR[4:1], 1'b0}; // R15
  assign dev_sel    = win_select_reg[SEL_FIELD_LSB +: 4]; // R12
  assign page_sel   = win_select_reg[PAGE_FIELD_LSB +: 4];
  assign hit_select = (word_ofs == WIN_SELECT_OFS); // R12
  assign hit_window = (word_ofs <= WIN_LAST_OFS); // R14
  assign sub_addr   = eff_addr(word_ofs, page_sel); // R13 R2

  logic sel_uart;
  logic sel_can;
  logic sel_adc;
  logic sel_gpio;

  assign sel_uart = hit_window && (dev_sel == SUB_UART); // R3
  assign sel_can  = hit_window && (dev_sel == SUB_CAN); // R1
  assign sel_adc  = hit_window && (dev_sel == SUB_ADC) && (sub_addr == ADC_REG_OFS); // R7 R8
  assign sel_gpio = hit_window && (dev_sel == SUB_GPIO); // R4

  // ----------------------------------------------------------------
  // window select register
  // ----------------------------------------------------------------
  // reserved upper byte is not stored
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      win_select_reg <= WIN_SELECT_RST;
    end else if (BUS_WR && hit_select) begin
      win_select_reg <= BUS_WDATA[7:0]; // R12 R3 R4 R7
    end
  end

  // ----------------------------------------------------------------
  // external sub-device buses
  // ----------------------------------------------------------------
  // registered strobes, address and data towards uart and can cores
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      UART_BUS <= '0;
      CAN_BUS  <= '0;
    end else begin
      UART_BUS.addr  <= sub_addr; // R3
      UART_BUS.wdata <= BUS_WDATA;
      UART_BUS.wr    <= BUS_WR && sel_uart;
      UART_BUS.rd    <= BUS_RD && sel_uart;
      CAN_BUS.addr   <= sub_addr; // R1 R2
      CAN_BUS.wdata  <= BUS_WDATA;
      CAN_BUS.wr     <= BUS_WR && sel_can;
      CAN_BUS.rd     <= BUS_RD && sel_can;
    end
  end

  // ----------------------------------------------------------------
  // gpio front end
  // ----------------------------------------------------------------
  // output word written at offset zero; input word is read only
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      GPIO_OUT <= GPIO_OUT_RST;
    end else if (BUS_WR && sel_gpio && sub_addr == GPIO_OUT_OFS) begin
      GPIO_OUT <= BUS_WDATA; // R5
    end
  end

  // ----------------------------------------------------------------
  // adc command store
  // ----------------------------------------------------------------
  logic [6:0]  adc_cmd_reg;
  logic [15:0] adc_result_reg;

  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      adc_cmd_reg <= ADC_CMD_RST;
    end else if (BUS_WR && sel_adc) begin
      adc_cmd_reg <= BUS_WDATA[ADC_CMD_BITS-1:0]; // R9
    end
  end

  // ----------------------------------------------------------------
  // adc serial link, free running
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_GAP   = 2'b00,
    ST_SHIFT = 2'b01,
    ST_DONE  = 2'b10
  } adc_state_e;

  adc_state_e  adc_state_reg;
  logic [15:0] frame_cnt_reg;
  logic [15:0] half_cnt_reg;
  logic [4:0]  bit_cnt_reg;
  logic [15:0] tx_shift_reg;
  logic [15:0] rx_shift_reg;
  logic        frame_tick;
  logic        half_tick;

  assign frame_tick = (frame_cnt_reg == 16'(FRAME_CYC - 1));
  assign half_tick  = (half_cnt_reg == 16'(SCK_HALF - 1));

  // conversion period counter, never waits for the host
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      frame_cnt_reg <= '0;
    end else if (frame_tick) begin
      frame_cnt_reg <= '0; // R10
    end else begin
      frame_cnt_reg <= frame_cnt_reg + 16'h0001;
    end
  end

  // serial clock half period divider, runs inside a frame only
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      half_cnt_reg <= '0;
    end else if (adc_state_reg != ST_SHIFT || half_tick) begin
      half_cnt_reg <= '0;
    end else begin
      half_cnt_reg <= half_cnt_reg + 16'h0001;
    end
  end

  // frame sequencer: command out msb first, result sampled on rise
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      adc_state_reg <= ST_GAP;
      bit_cnt_reg   <= '0;
      tx_shift_reg  <= '0;
      rx_shift_reg  <= '0;
      ADC_CS_N      <= 1'b1;
      ADC_SCK       <= 1'b0;
      ADC_MOSI      <= 1'b0;
    end else begin
      case (adc_state_reg)
        ST_GAP: begin
          if (frame_tick) begin
            adc_state_reg <= ST_SHIFT; // R10
            tx_shift_reg  <= {adc_cmd_reg, 9'h000} << 1; // R9
            ADC_MOSI      <= adc_cmd_reg[6];
            ADC_CS_N      <= 1'b0;
            bit_cnt_reg   <= '0;
          end
        end
        ST_SHIFT: begin
          if (half_tick) begin
            ADC_SCK <= ~ADC_SCK;
            if (!ADC_SCK) begin
              rx_shift_reg <= {rx_shift_reg[14:0], ADC_MISO};
            end else begin
              ADC_MOSI     <= tx_shift_reg[15]; // R9
              tx_shift_reg <= {tx_shift_reg[14:0], 1'b0};
              bit_cnt_reg  <= bit_cnt_reg + 5'h01;
              if (bit_cnt_reg == 5'(ADC_FRAME_BITS - 1)) begin
                adc_state_reg <= ST_DONE;
              end
            end
          end
        end
        ST_DONE: begin
          ADC_CS_N      <= 1'b1;
          ADC_MOSI      <= 1'b0;
          adc_state_reg <= ST_GAP;
        end
        default: begin
          adc_state_reg <= ST_GAP;
          ADC_CS_N      <= 1'b1;
          ADC_SCK       <= 1'b0;
        end
      endcase
    end
  end

  // last completed conversion held for host reads
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      adc_result_reg <= ADC_RESULT_RST;
    end else if (adc_state_reg == ST_DONE) begin
      adc_result_reg <= rx_shift_reg; // R11
    end
  end

  // ----------------------------------------------------------------
  // read return path
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    RS_ZERO   = 3'b000,
    RS_SELECT = 3'b001,
    RS_UART   = 3'b010,
    RS_CAN    = 3'b011,
    RS_LOCAL  = 3'b100
  } read_src_e;

  read_src_e   rd_src_reg;
  logic        rd_pend_reg;
  logic [15:0] local_rdata_reg;
  logic [15:0] local_rdata;

  // internal read value chosen in the request cycle
  always_comb begin
    local_rdata = 16'h0000;
    if (sel_adc) begin
      local_rdata = adc_result_reg; // R11 R8
    end else if (sel_gpio && sub_addr == GPIO_OUT_OFS) begin
      local_rdata = GPIO_OUT; // R5
    end else if (sel_gpio && sub_addr == GPIO_IN_OFS) begin
      local_rdata = {8'h00, GPIO_IN}; // R6 R16
    end
  end

  // first stage: note source of the pending read
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rd_pend_reg     <= 1'b0;
      rd_src_reg      <= RS_ZERO;
      local_rdata_reg <= '0;
    end else begin
      rd_pend_reg     <= BUS_RD;
      local_rdata_reg <= local_rdata;
      if (hit_select) begin
        rd_src_reg <= RS_SELECT;
      end else if (sel_uart) begin
        rd_src_reg <= RS_UART;
      end else if (sel_can) begin
        rd_src_reg <= RS_CAN;
      end else if (sel_adc || sel_gpio) begin
        rd_src_reg <= RS_LOCAL;
      end else begin
        rd_src_reg <= RS_ZERO;
      end
    end
  end

  // second stage: capture answer, sub-device data valid here
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      BUS_RDATA  <= '0;
      BUS_RVALID <= 1'b0;
    end else begin
      BUS_RVALID <= rd_pend_reg;
      if (rd_pend_reg) begin
        case (rd_src_reg)
          RS_SELECT: BUS_RDATA <= {8'h00, win_select_reg}; // R12
          RS_UART:   BUS_RDATA <= UART_RDATA; // R3
          RS_CAN:    BUS_RDATA <= CAN_RDATA; // R1
          RS_LOCAL:  BUS_RDATA <= local_rdata_reg;
          default:   BUS_RDATA <= 16'h0000;
        endcase
      end
    end
  end

endmodule

`default_nettype wire

// [window_router_pkg.sv]
package window_router_pkg;

  // ----------------------------------------------------------------
  // host window layout
  // ----------------------------------------------------------------
  localparam int          HOST_ADDR_W    = 5;
  localparam int          DATA_W         = 16;
  localparam int          SUB_ADDR_W     = 8;
  localparam logic [4:0]  WIN_SELECT_OFS = 5'h1e;
  localparam logic [4:0]  WIN_LAST_OFS   = 5'h1d;
  localparam int          SEL_FIELD_LSB  = 4;
  localparam int          PAGE_FIELD_LSB = 0;
  localparam int          PAGE_STEP_LSB  = 4;
  localparam logic [7:0]  WIN_SELECT_RST = 8'h00;

  // ----------------------------------------------------------------
  // sub-device codes and register offsets
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    SUB_UART = 4'h0,
    SUB_CAN  = 4'h1,
    SUB_ADC  = 4'h2,
    SUB_GPIO = 4'h3
  } sub_sel_e;

  localparam logic [7:0]  GPIO_OUT_OFS   = 8'h00;
  localparam logic [7:0]  GPIO_IN_OFS    = 8'h02;
  localparam logic [7:0]  ADC_REG_OFS    = 8'h00;
  localparam logic [15:0] GPIO_OUT_RST   = 16'h0000;
  localparam logic [15:0] ADC_RESULT_RST = 16'h0000;
  localparam logic [6:0]  ADC_CMD_RST    = 7'h00;

  // ----------------------------------------------------------------
  // converter link timing
  // ----------------------------------------------------------------
  localparam longint CLK_HZ          = 250000000;
  localparam longint ADC_RATE_HZ     = 190000;
  localparam int     ADC_FRAME_CYC   = int'(CLK_HZ / ADC_RATE_HZ);
  localparam int     ADC_SCK_HALF    = 16;
  localparam int     ADC_FRAME_BITS  = 16;
  localparam int     ADC_CMD_BITS    = 7;

  // sub-device bus carried as one bundle
  typedef struct packed {
    logic [SUB_ADDR_W-1:0] addr;
    logic [DATA_W-1:0]     wdata;
    logic                  wr;
    logic                  rd;
  } sub_bus_s;

endpackage
